/* common/retimer_regs_pkg.sv */
// Register map, field positions and reset values of the shared register set
package retimer_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_IDENT = 8'h01;
  localparam logic [7:0] ADDR_SPARE2 = 8'h02;
  localparam logic [7:0] ADDR_SPARE3 = 8'h03;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h05;
  localparam logic [7:0] ADDR_SPARE6 = 8'h06;
  localparam logic [7:0] ADDR_SPARE7 = 8'h07;
  localparam logic [7:0] ADDR_SELECT = 8'hff;

  // Field positions
  localparam int CTRL_SOFT_RST_BIT = 6;
  localparam int CTRL_MASTER_RST_BIT = 5;
  localparam int CTRL_FORCE_LOAD_BIT = 4;
  localparam int STAT_LOAD_OFF_BIT = 7;
  localparam int STAT_DONE_BIT = 4;
  localparam int SEL_BCAST_BIT = 3;
  localparam int SEL_EN_BIT = 2;
  localparam int SEL_LANE_LSB = 0;
  localparam int SEL_LANE_W = 2;
  localparam int STRAP_LSB = 4;

  // Write masks: self-clearing bits are never stored
  localparam logic [7:0] CTRL_STORE_MASK = 8'h9f;
  localparam logic [7:0] STAT_STORE_MASK = 8'he0;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] STAT_RW_RST = 8'h00;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic [7:0] SPARE7_RST = 8'h05;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] SELECT_READ_VAL = 8'h00;

  // Length of the generated reset pulses, in clock cycles
  localparam int RST_PULSE_CYCLES = 1;

  // Configuration load tracker
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b01,
    LOAD_BUSY = 2'b10
  } load_state_t;

endpackage

/* hw/sc_pulse.sv */
// Self-clearing control bit turned into a reset pulse of fixed length
`timescale 1ns/1ns
`default_nettype none
module sc_pulse #(
  parameter int PULSE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic set,
  output logic pulse
);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) $error("sc_pulse: PULSE_CYCLES out of range");
  end

  logic [7:0] cnt_ff;

  // Count down the pulse; a new set restarts it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
    end else if (set) begin
      cnt_ff <= 8'(PULSE_CYCLES);
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  assign pulse = (cnt_ff != 8'h00);

  logic [8:0] run_ff;

  // Cycles the pulse has stood since the last set, for the length check
  always_ff @(posedge clk) begin
    if (!nrst || set || !pulse) begin
      run_ff <= 9'h000;
    end else begin
      run_ff <= run_ff + 9'h001;
    end
  end

  chk_pulse_follows_set: assert property (@(posedge clk) disable iff (!nrst)
    set |=> pulse) else $error("reset pulse missing after set");
  chk_pulse_ends: assert property (@(posedge clk) disable iff (!nrst)
    pulse |-> run_ff < 9'(PULSE_CYCLES)) else $error("reset pulse too long");

endmodule // sc_pulse
`default_nettype wire

/* hw/lane_steer.sv */
// Decode of one register access into shared, select or lane targets
`timescale 1ns/1ns
`default_nettype none
module lane_steer #(
  parameter int LANES = 4
) (
  input wire logic [7:0] sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  output logic sel_wr,
  output logic shared_wr,
  output logic shared_rd,
  output logic [LANES-1:0] lane_wr,
  output logic lane_rd
);

  initial begin
    if (LANES != 4) $error("lane_steer: select field serves four lanes");
  end

  logic is_sel;
  logic lane_on;
  logic [LANES-1:0] one_lane;

  assign is_sel = (addr == retimer_regs_pkg::ADDR_SELECT);
  assign lane_on = sel[retimer_regs_pkg::SEL_EN_BIT];
  assign one_lane = LANES'(1) << sel[retimer_regs_pkg::SEL_LANE_LSB +: retimer_regs_pkg::SEL_LANE_W];

  // Select register always lives in the shared set
  assign sel_wr = wr && is_sel;
  assign shared_wr = wr && !is_sel && !lane_on;
  assign shared_rd = rd && (is_sel || !lane_on);
  assign lane_rd = rd && !is_sel && lane_on;

  always_comb begin
    lane_wr = '0;
    if (wr && !is_sel && lane_on) begin
      lane_wr = sel[retimer_regs_pkg::SEL_BCAST_BIT] ? '1 : one_lane;
    end
  end

endmodule // lane_steer
`default_nettype wire

/* hw/shared_regs_channel_select.sv */
// Shared control/status registers and lane register-set steering
//
// What this block does
// - Control bit 6 restores shared registers, self-clears
// - Control bit 5 resets EEPROM master, self-clears
// - Control bit 4 forces EEPROM configuration load
// - Status bit 7 blocks master-mode EEPROM load
// - Status bit 4 reads one when loading done
// - Status bits 3:0 show lane 0..3 interrupts
// - Enable plus broadcast writes all four lanes
// - Lane reads come from selected lane only
// - Lane sets reached only while enable set
// - Writes to 0xff always hit select register
// - Select register readback value is fixed at 0x00
// - Select values 00, 04-07, 0c-0f decode targets
// - Writes to read-only fields are ignored
// - Selection persists until select is rewritten or control bit 6 soft reset clears it
`timescale 1ns/1ns
`default_nettype none
module shared_regs_channel_select #(
  parameter int LANES = 4,
  parameter logic [7:0] IDENT_CODE = 8'h5a // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] addr_strap,
  input wire logic [LANES-1:0] lane_irq,
  input wire logic boot_load_req,
  input wire logic load_finished,
  output logic config_load_start,
  output logic force_config_load,
  output logic eeprom_master_reset,
  output logic [LANES-1:0] lane_wr,
  output logic lane_rd,
  output logic [1:0] lane_index,
  output logic [7:0] lane_addr,
  output logic [7:0] lane_wdata,
  input wire logic [LANES*8-1:0] lane_rdata
);

  initial begin
    if (LANES != 4) $error("shared_regs_channel_select: LANES must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [7:0] sel_ff;
  logic sel_wr;
  logic shared_wr;
  logic shared_rd;
  logic [LANES-1:0] nxt_lane_wr;
  logic nxt_lane_rd;
  logic shared_rst;

  lane_steer #(.LANES(LANES)) u_steer (
    .sel(sel_ff),
    .wr(reg_wr),
    .rd(reg_rd),
    .addr(reg_addr),
    .sel_wr(sel_wr),
    .shared_wr(shared_wr),
    .shared_rd(shared_rd),
    .lane_wr(nxt_lane_wr),
    .lane_rd(nxt_lane_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared registers

  logic [7:0] ctrl_ff;
  logic [7:0] stat_rw_ff;
  logic [7:0] spare2_ff;
  logic [7:0] spare3_ff;
  logic [7:0] spare6_ff;
  logic [7:0] spare7_ff;
  logic [LANES-1:0] irq_ff;
  logic [3:0] strap_ff;
  logic soft_rst_set;
  logic master_rst_set;

  assign soft_rst_set = shared_wr && (reg_addr == retimer_regs_pkg::ADDR_CTRL)
                        && reg_wdata[retimer_regs_pkg::CTRL_SOFT_RST_BIT];
  assign master_rst_set = shared_wr && (reg_addr == retimer_regs_pkg::ADDR_CTRL)
                          && reg_wdata[retimer_regs_pkg::CTRL_MASTER_RST_BIT];

  sc_pulse #(.PULSE_CYCLES(retimer_regs_pkg::RST_PULSE_CYCLES)) u_soft_rst (
    .clk(clk),
    .nrst(nrst),
    .set(soft_rst_set),
    .pulse(shared_rst)
  );

  sc_pulse #(.PULSE_CYCLES(retimer_regs_pkg::RST_PULSE_CYCLES)) u_master_rst (
    .clk(clk),
    .nrst(nrst),
    .set(master_rst_set),
    .pulse(eeprom_master_reset)
  );

  // writable shared registers, restored by the soft reset
  always_ff @(posedge clk) begin
    if (!nrst || shared_rst) begin
      ctrl_ff <= retimer_regs_pkg::CTRL_RST;
      stat_rw_ff <= retimer_regs_pkg::STAT_RW_RST;
      spare2_ff <= retimer_regs_pkg::SPARE_RST;
      spare3_ff <= retimer_regs_pkg::SPARE_RST;
      spare6_ff <= retimer_regs_pkg::SPARE_RST;
      spare7_ff <= retimer_regs_pkg::SPARE7_RST;
    end else if (shared_wr) begin
      case (reg_addr)
        retimer_regs_pkg::ADDR_CTRL: ctrl_ff <= reg_wdata & retimer_regs_pkg::CTRL_STORE_MASK;
        retimer_regs_pkg::ADDR_STAT: stat_rw_ff <= reg_wdata & retimer_regs_pkg::STAT_STORE_MASK;
        retimer_regs_pkg::ADDR_SPARE2: spare2_ff <= reg_wdata;
        retimer_regs_pkg::ADDR_SPARE3: spare3_ff <= reg_wdata;
        retimer_regs_pkg::ADDR_SPARE6: spare6_ff <= reg_wdata;
        retimer_regs_pkg::ADDR_SPARE7: spare7_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || shared_rst) begin
      sel_ff <= retimer_regs_pkg::SEL_RST;
    end else if (sel_wr) begin
      sel_ff <= reg_wdata;
    end
  end

  // lane interrupt levels and strap sampling
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_ff <= '0;
      strap_ff <= 4'h0;
    end else begin
      irq_ff <= lane_irq;
      strap_ff <= addr_strap;
    end
  end

  assign force_config_load = ctrl_ff[retimer_regs_pkg::CTRL_FORCE_LOAD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration load tracker

  retimer_regs_pkg::load_state_t load_state_ff;
  logic force_q_ff;
  logic load_off;
  logic load_req;
  logic load_done;

  assign load_off = stat_rw_ff[retimer_regs_pkg::STAT_LOAD_OFF_BIT];
  // forced load; boot load blocked when disabled
  assign load_req = (force_config_load && !force_q_ff) || (boot_load_req && !load_off);
  // done while no load is running
  assign load_done = (load_state_ff == retimer_regs_pkg::LOAD_IDLE);

  // Edge detect of the force bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      force_q_ff <= 1'b0;
    end else begin
      force_q_ff <= force_config_load;
    end
  end

  // Track a load from start to finish
  always_ff @(posedge clk) begin
    if (!nrst || eeprom_master_reset) begin
      load_state_ff <= retimer_regs_pkg::LOAD_IDLE;
      config_load_start <= 1'b0;
    end else begin
      config_load_start <= 1'b0;
      case (load_state_ff)
        retimer_regs_pkg::LOAD_IDLE: begin
          if (load_req) begin
            load_state_ff <= retimer_regs_pkg::LOAD_BUSY;
            config_load_start <= 1'b1;
          end
        end
        retimer_regs_pkg::LOAD_BUSY: begin
          if (load_finished) load_state_ff <= retimer_regs_pkg::LOAD_IDLE;
        end
        default: load_state_ff <= retimer_regs_pkg::LOAD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux of the shared set

  logic [7:0] shared_val;
  logic [LANES-1:0] irq_rev;

  // lane 0 on bit 3 through lane 3 on bit 0
  always_comb begin
    for (int i = 0; i < LANES; i++) irq_rev[LANES-1-i] = irq_ff[i];
  end

  always_comb begin
    case (reg_addr)
      retimer_regs_pkg::ADDR_STRAP: shared_val = {strap_ff, 4'h0};
      retimer_regs_pkg::ADDR_IDENT: shared_val = IDENT_CODE;
      retimer_regs_pkg::ADDR_SPARE2: shared_val = spare2_ff;
      retimer_regs_pkg::ADDR_SPARE3: shared_val = spare3_ff;
      retimer_regs_pkg::ADDR_CTRL: shared_val = ctrl_ff;
      retimer_regs_pkg::ADDR_STAT: shared_val = {stat_rw_ff[7:5], load_done, irq_rev};
      retimer_regs_pkg::ADDR_SPARE6: shared_val = spare6_ff;
      retimer_regs_pkg::ADDR_SPARE7: shared_val = spare7_ff;
      // select readback is a fixed value
      retimer_regs_pkg::ADDR_SELECT: shared_val = retimer_regs_pkg::SELECT_READ_VAL;
      default: shared_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane side and read pipeline

  logic rd_pend_ff;
  logic rd_lane_ff;
  logic [7:0] rd_hold_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lane_wr <= '0;
      lane_rd <= 1'b0;
      lane_index <= 2'h0;
      lane_addr <= 8'h00;
      lane_wdata <= 8'h00;
    end else begin
      lane_wr <= nxt_lane_wr;
      lane_rd <= nxt_lane_rd;
      lane_index <= sel_ff[retimer_regs_pkg::SEL_LANE_LSB +: retimer_regs_pkg::SEL_LANE_W];
      lane_addr <= reg_addr;
      lane_wdata <= reg_wdata;
    end
  end

  // First read stage: note target, hold shared value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_pend_ff <= 1'b0;
      rd_lane_ff <= 1'b0;
      rd_hold_ff <= 8'h00;
    end else begin
      rd_pend_ff <= reg_rd;
      rd_lane_ff <= nxt_lane_rd;
      rd_hold_ff <= shared_val;
    end
  end

  // Second read stage: answer to the host
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rvalid <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rvalid <= rd_pend_ff;
      reg_rdata <= rd_lane_ff ? lane_rdata[lane_index*8 +: 8] : rd_hold_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_soft_rst_defaults: assert property (@(posedge clk) disable iff (!nrst)
    soft_rst_set |=> ##1 (ctrl_ff == retimer_regs_pkg::CTRL_RST) && (sel_ff == retimer_regs_pkg::SEL_RST))
    else $error("soft reset did not restore defaults");
  chk_master_rst_out: assert property (@(posedge clk) disable iff (!nrst)
    master_rst_set |=> eeprom_master_reset) else $error("master reset not pulsed");
  chk_force_starts: assert property (@(posedge clk) disable iff (!nrst)
    $rose(force_config_load) && load_done && !eeprom_master_reset |=> config_load_start)
    else $error("forced load did not start");
  chk_boot_blocked: assert property (@(posedge clk) disable iff (!nrst)
    boot_load_req && load_off && !(force_config_load && !force_q_ff) |=> !config_load_start)
    else $error("load started while disabled");
  chk_done_flag: assert property (@(posedge clk) disable iff (!nrst)
    config_load_start ##0 (!load_finished && !eeprom_master_reset) [*2] |-> !load_done)
    else $error("done flag high during load");
  chk_irq_order: assert property (@(posedge clk) disable iff (!nrst)
    ##1 irq_rev[3] == $past(lane_irq[0]) && irq_rev[0] == $past(lane_irq[3]))
    else $error("lane interrupt bit order wrong");
  chk_bcast_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr != retimer_regs_pkg::ADDR_SELECT && sel_ff[3:2] == 2'b11 |=> lane_wr == '1)
    else $error("broadcast write missed a lane");
  chk_read_one_lane: assert property (@(posedge clk) disable iff (!nrst)
    nxt_lane_rd |=> lane_rd && lane_index == $past(sel_ff[1:0]) ##1 reg_rvalid)
    else $error("lane read not from selected lane");
  chk_shared_when_off: assert property (@(posedge clk) disable iff (!nrst)
    (reg_wr || reg_rd) && !sel_ff[retimer_regs_pkg::SEL_EN_BIT] |=> lane_wr == '0 && !lane_rd)
    else $error("lane reached while disabled");
  chk_select_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == retimer_regs_pkg::ADDR_SELECT && !shared_rst |=> sel_ff == $past(reg_wdata) && lane_wr == '0)
    else $error("select write misrouted");
  chk_ro_ignored: assert property (@(posedge clk) disable iff (!nrst)
    shared_wr && reg_addr == retimer_regs_pkg::ADDR_STAT |=> stat_rw_ff[4:0] == 5'h00)
    else $error("read-only field changed by write");
  chk_select_holds: assert property (@(posedge clk) disable iff (!nrst)
    !sel_wr && !shared_rst |=> $stable(sel_ff)) else $error("selection changed without write");
  chk_sc_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    shared_rd && reg_addr == retimer_regs_pkg::ADDR_CTRL |-> ##2 reg_rvalid && reg_rdata[6:5] == 2'b00)
    else $error("self-clearing bit read back one");

  cov_bcast: cover property (@(posedge clk) disable iff (!nrst) lane_wr == '1);
  cov_lane_read: cover property (@(posedge clk) disable iff (!nrst) lane_rd ##2 reg_rvalid);
  cov_soft_rst: cover property (@(posedge clk) disable iff (!nrst) shared_rst);
  cov_load_done: cover property (@(posedge clk) disable iff (!nrst) config_load_start ##[1:20] load_done);

endmodule // shared_regs_channel_select
`default_nettype wire

/* tb/smbus_host_model.sv */
// Register host model: one-cycle write and read strobes toward the block
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Write strobe for one cycle; released lines show inverted values
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // Read strobe for one cycle, answer taken at the edge where it shows
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        data = reg_rdata;
      end
    end
  endtask

  task automatic select_set(input logic [3:0] sel);
    write_reg(8'hff, {4'h0, sel});
  endtask
endmodule // smbus_host_model
`default_nettype wire

/* tb/shared_regs_channel_select_bench.sv */
// Self-checking bench for the shared registers and lane steering
`timescale 1ns/1ns
`default_nettype none
module shared_regs_channel_select_bench;
  typedef struct packed {logic [7:0] addr; logic [7:0] exp;} row_t;
  logic clk;
  logic nrst;
  logic reg_wr, reg_rd, reg_rvalid, boot_load_req, load_finished;
  logic config_load_start, force_config_load, eeprom_master_reset, lane_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lane_addr, lane_wdata;
  logic [3:0] addr_strap, lane_irq, lane_wr;
  logic [1:0] lane_index;
  logic [31:0] lane_rdata;
  logic [7:0] lane_mem [4][256];
  row_t rows [9];
  int err_count, tests_run, cycles, start_cnt, mres_cnt, s;

  ////////////////////////////////////////////////////////////////////////
  shared_regs_channel_select #(.LANES(4), .IDENT_CODE(8'h3c)) i_dut ( // Ident value arbitrary
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .addr_strap(addr_strap), .lane_irq(lane_irq), .boot_load_req(boot_load_req),
    .load_finished(load_finished), .config_load_start(config_load_start),
    .force_config_load(force_config_load), .eeprom_master_reset(eeprom_master_reset),
    .lane_wr(lane_wr), .lane_rd(lane_rd), .lane_index(lane_index), .lane_addr(lane_addr),
    .lane_wdata(lane_wdata), .lane_rdata(lane_rdata));

  smbus_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Lane register sets: all four answer, the block picks one
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_rdata[8*g +: 8] = lane_mem[g][lane_addr];
  end

  // Lane writes land on the edge after the strobe shows
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (lane_wr[k] === 1'b1) begin
        lane_mem[k][lane_addr] <= lane_wdata;
      end
    end
  end

  // Pulse counters and cycle ceiling
  always @(posedge clk) begin
    cycles++;
    if (config_load_start === 1'b1) start_cnt++;
    if (eeprom_master_reset === 1'b1) mres_cnt++;
    if (cycles == 4000) begin
      err_count++;
      $display("Error at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // Clock of 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string what);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("Error at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.read_reg(addr, d, ok);
    check1(ok, 1'b1, "read answer");
    check8(d, exp, "read data");
  endtask

  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 0) boot_load_req = 1'b1;
    else load_finished = 1'b1;
    @(negedge clk);
    boot_load_req = 1'b0;
    load_finished = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    boot_load_req = 1'b0;
    load_finished = 1'b0;
    addr_strap = 4'ha;
    lane_irq = 4'h0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    start_cnt = 0;
    mres_cnt = 0;
    for (int k = 0; k < 4; k++) for (int a = 0; a < 256; a++) lane_mem[k][a] = 8'h00;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    rows = '{'{8'h00, 8'ha0}, '{8'h01, 8'h3c}, '{8'h02, 8'h00}, '{8'h03, 8'h00},
      '{8'h04, retimer_regs_pkg::CTRL_RST}, '{8'h05, 8'h10}, '{8'h06, 8'h00},
      '{8'h07, retimer_regs_pkg::SPARE7_RST}, '{8'hff, retimer_regs_pkg::SELECT_READ_VAL}};
    foreach (rows[i]) rd_check(rows[i].addr, rows[i].exp);
    $display("test reset values done");
    i_host.write_reg(8'h05, 8'h9f);
    rd_check(8'h05, 8'h90);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      lane_irq = 4'h1 << k;
      rd_check(8'h05, 8'h90 | (8'h08 >> k));
    end
    lane_irq = 4'h0;
    $display("test status done");
    s = start_cnt;
    pulse(0);
    repeat (3) @(negedge clk);
    check_count(start_cnt, s, "blocked load");
    i_host.write_reg(8'h04, 8'h11);
    repeat (3) @(negedge clk);
    check_count(start_cnt, s + 1, "forced load");
    check1(force_config_load, 1'b1, "force level");
    rd_check(8'h05, 8'h80);
    pulse(1);
    rd_check(8'h05, 8'h90);
    s = mres_cnt;
    i_host.write_reg(8'h04, 8'h31);
    repeat (3) @(negedge clk);
    check_count(mres_cnt, s + 1, "master reset");
    rd_check(8'h04, 8'h11);
    $display("test load control done");
    i_host.write_reg(8'h06, 8'ha5);
    i_host.write_reg(8'h07, 8'h3c);
    i_host.write_reg(8'h04, 8'h40);
    rd_check(8'h06, 8'h00);
    rd_check(8'h07, retimer_regs_pkg::SPARE7_RST);
    rd_check(8'h04, retimer_regs_pkg::CTRL_RST);
    rd_check(8'h05, 8'h10);
    $display("test soft reset done");
    i_host.select_set(4'hc);
    i_host.write_reg(8'h10, 8'h55);
    repeat (2) @(negedge clk);
    for (int k = 0; k < 4; k++) check8(lane_mem[k][8'h10], 8'h55, "broadcast");
    for (int k = 0; k < 4; k++) begin
      i_host.select_set(4'(4 + k));
      i_host.write_reg(8'h10, 8'(8'h60 + k));
    end
    for (int k = 0; k < 4; k++) begin
      i_host.select_set(4'(12 + k));
      rd_check(8'h10, 8'(8'h60 + k));
      i_host.select_set(4'(4 + k));
      rd_check(8'h10, 8'(8'h60 + k));
    end
    i_host.select_set(4'h5);
    i_host.write_reg(8'h21, 8'ha1);
    i_host.write_reg(8'h22, 8'ha2);
    repeat (2) @(negedge clk);
    check8(lane_mem[1][8'h21], 8'ha1, "held select");
    check8(lane_mem[1][8'h22], 8'ha2, "held select");
    check8(lane_mem[0][8'h21], 8'h00, "other lane");
    i_host.select_set(4'h8);
    i_host.write_reg(8'h06, 8'h12);
    rd_check(8'h06, 8'h12);
    for (int k = 0; k < 4; k++) check8(lane_mem[k][8'h06], 8'h00, "no lane");
    for (int k = 0; k < 4; k++) check8(lane_mem[k][8'hff], 8'h00, "select only");
    i_host.select_set(4'h0);
    rd_check(8'h06, 8'h12);
    $display("test lane steering done");
    addr_strap = 4'h5;
    i_host.write_reg(8'h00, 8'hff);
    rd_check(8'h00, 8'h50);
    $display("test read-only strap done");
    i_host.write_reg(8'h06, 8'h77);
    i_host.select_set(4'h5);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd_check(8'h06, 8'h00);
    rd_check(8'h05, 8'h10);
    s = start_cnt;
    pulse(0);
    repeat (3) @(negedge clk);
    check_count(start_cnt, s + 1, "boot load");
    rd_check(8'h05, 8'h00);
    pulse(1);
    rd_check(8'h05, 8'h10);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // shared_regs_channel_select_bench
`default_nettype wire
